// >>> rtl/gcs_top.sv
// Global clock source selection and clock-mode register block.
`timescale 1ns/100ps
`default_nettype none
`include "gcs_cfg.svh"
module gcs_top #(
    parameter int N_CH = 8,
    parameter int SEL_W = 3,
    parameter int STRAP_W = 11,
    parameter int ADDR_W = 16
) (
    // Clock, reset and enable
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic CE,
    // Register port
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [7:0] WR_DATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    output logic [7:0] RD_DATA,
    // Per-channel sources and line standards
    input wire logic [N_CH-1:0] CH_FRAME_SYNC,
    input wire logic [N_CH-1:0] CH_RECOV_CLK,
    input wire logic [N_CH-1:0] CH_STD_T1,
    // Controller interface kind and strap pins
    input wire logic SERIAL_CTRL_IF,
    input wire logic [STRAP_W-1:0] STRAP_DATA,
    // Clock outputs and clock-system controls
    output logic FRAME_SYNC_OUTPUT,
    output logic RECOVERED_CLOCK_OUT_ONE,
    output var gcs_pkg::gcs_adj_t FREQ_ADJUST,
    output var gcs_pkg::gcs_phase_t PHASE_DECODER,
    output logic VARIABLE_MASTER_CLOCK_EN,
    output logic CLOCK_SYS_RESET,
    output logic [STRAP_W-1:0] STRAP_CFG
);
    import gcs_pkg::*;

    // Software-visible registers.
    logic [7:0] global_clock_source_select_r;
    logic [7:0] global_clock_source_select_nxt;
    logic [7:0] e1_freq_adjust_low_r;
    logic [7:0] e1_freq_adjust_low_nxt;
    logic [7:0] clock_mode_ctrl_e1_high_r;
    logic [7:0] clock_mode_ctrl_e1_high_nxt;
    logic [7:0] t1_freq_adjust_low_r;
    logic [7:0] t1_freq_adjust_low_nxt;
    logic [7:0] t1_freq_adjust_high_reg_r;
    logic [7:0] t1_freq_adjust_high_reg_nxt;
    logic [7:0] rd_data_r;
    logic [7:0] rd_data_nxt;

    // Clock-mode state.
    gcs_std_t std_prev_r;
    gcs_std_t std_prev_nxt;
    gcs_std_t std_now;
    gcs_adj_t adj_r;
    gcs_adj_t adj_nxt;
    gcs_phase_t phase_r;
    gcs_phase_t phase_nxt;
    logic vfreq_r;
    logic vfreq_nxt;
    logic clk_sys_rst_r;
    logic clk_sys_rst_nxt;

    // Decoded fields and status terms.
    logic fixed_mode;
    logic mixed_std;
    logic strap_mask;
    logic wr_hit;
    logic [SEL_W-1:0] fsync_sel;
    logic [SEL_W-1:0] recov_sel;
    logic [7:0] status_word;

    assign fixed_mode = !clock_mode_ctrl_e1_high_r[`GCS_VFREQ_BIT];
    assign std_now = gcs_std_t'(CH_STD_T1[0]);
    // Port 1 is the reference standard; a disagreement shows in status so
    // software can find a fixed-mode setup that breaks the common standard.
    assign mixed_std = !((&CH_STD_T1) || !(|CH_STD_T1));
    assign strap_mask = fixed_mode && SERIAL_CTRL_IF;
    assign wr_hit = CE && WR_STB;
    assign fsync_sel =
        global_clock_source_select_r[`GCS_FSYNC_SEL_HI:`GCS_FSYNC_SEL_LO];
    assign recov_sel =
        global_clock_source_select_r[`GCS_RECOV_SEL_HI:`GCS_RECOV_SEL_LO];
    assign status_word = {4'h0, strap_mask, std_now, mixed_std, fixed_mode};

    // Register writes; reserved bits are dropped so they read as zero.
    always_comb begin
        global_clock_source_select_nxt = global_clock_source_select_r;
        e1_freq_adjust_low_nxt = e1_freq_adjust_low_r;
        clock_mode_ctrl_e1_high_nxt = clock_mode_ctrl_e1_high_r;
        t1_freq_adjust_low_nxt = t1_freq_adjust_low_r;
        t1_freq_adjust_high_reg_nxt = t1_freq_adjust_high_reg_r;
        if (wr_hit) begin
            case (ADDR)
                `GCS_OFF_SRC_SEL: begin
                    global_clock_source_select_nxt =
                        WR_DATA & `GCS_MASK_SRC_SEL;
                end
                `GCS_OFF_E1_LOW: begin
                    e1_freq_adjust_low_nxt = WR_DATA;
                end
                `GCS_OFF_MODE: begin
                    clock_mode_ctrl_e1_high_nxt = WR_DATA;
                end
                `GCS_OFF_T1_LOW: begin
                    t1_freq_adjust_low_nxt = WR_DATA;
                end
                `GCS_OFF_T1_HIGH: begin
                    t1_freq_adjust_high_reg_nxt =
                        WR_DATA & `GCS_MASK_T1_HIGH;
                end
                default: begin
                    global_clock_source_select_nxt =
                        global_clock_source_select_r;
                end
            endcase
        end
    end

    // Read data stand for exactly one cycle after the strobe; an unmapped
    // address answers zero so software never sees stale data.
    always_comb begin
        rd_data_nxt = 8'h00;
        if (RD_STB) begin
            case (ADDR)
                `GCS_OFF_SRC_SEL: rd_data_nxt = global_clock_source_select_r;
                `GCS_OFF_E1_LOW: rd_data_nxt = e1_freq_adjust_low_r;
                `GCS_OFF_MODE: rd_data_nxt = clock_mode_ctrl_e1_high_r;
                `GCS_OFF_T1_LOW: rd_data_nxt = t1_freq_adjust_low_r;
                `GCS_OFF_T1_HIGH: rd_data_nxt = t1_freq_adjust_high_reg_r;
                `GCS_OFF_STATUS: rd_data_nxt = status_word;
                default: rd_data_nxt = 8'h00;
            endcase
        end
    end

    // Register file and read port.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            global_clock_source_select_r <= `GCS_RST_SRC_SEL;
            e1_freq_adjust_low_r <= `GCS_RST_E1_LOW;
            clock_mode_ctrl_e1_high_r <= `GCS_RST_MODE;
            t1_freq_adjust_low_r <= `GCS_RST_T1_LOW;
            t1_freq_adjust_high_reg_r <= `GCS_RST_T1_HIGH;
            rd_data_r <= 8'h00;
        end else if (CE) begin
            global_clock_source_select_r <= global_clock_source_select_nxt;
            e1_freq_adjust_low_r <= e1_freq_adjust_low_nxt;
            clock_mode_ctrl_e1_high_r <= clock_mode_ctrl_e1_high_nxt;
            t1_freq_adjust_low_r <= t1_freq_adjust_low_nxt;
            t1_freq_adjust_high_reg_r <= t1_freq_adjust_high_reg_nxt;
            rd_data_r <= rd_data_nxt;
        end
    end

    // Clock-mode outputs. Fixed mode forces every adjust word and decoder
    // bit to its default, because the clocking then tunes itself and a
    // stale software value must not leak into it.
    always_comb begin
        vfreq_nxt = clock_mode_ctrl_e1_high_r[`GCS_VFREQ_BIT];
        std_prev_nxt = std_now;
        adj_nxt.e1 = {clock_mode_ctrl_e1_high_r[`GCS_NIB_HI:`GCS_NIB_LO],
                      e1_freq_adjust_low_r};
        adj_nxt.t1 = {t1_freq_adjust_high_reg_r[`GCS_NIB_HI:`GCS_NIB_LO],
                      t1_freq_adjust_low_r};
        phase_nxt.demand = clock_mode_ctrl_e1_high_r[`GCS_DEMAND_BIT];
        phase_nxt.direction = clock_mode_ctrl_e1_high_r[`GCS_DIRECTION_BIT];
        phase_nxt.sw = clock_mode_ctrl_e1_high_r[`GCS_SWITCH_BIT];
        clk_sys_rst_nxt = 1'b0;
        if (fixed_mode) begin
            adj_nxt = '0;
            phase_nxt = '0;
            clk_sys_rst_nxt = (std_now != std_prev_r);
        end
    end

    // The previous standard is tracked in both modes, so entering fixed
    // mode alone never fires a clock-system reset.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            std_prev_r <= GCS_STD_E1;
            adj_r <= '0;
            phase_r <= '0;
            vfreq_r <= 1'b1;
            clk_sys_rst_r <= 1'b0;
        end else if (CE) begin
            std_prev_r <= std_prev_nxt;
            adj_r <= adj_nxt;
            phase_r <= phase_nxt;
            vfreq_r <= vfreq_nxt;
            clk_sys_rst_r <= clk_sys_rst_nxt;
        end
    end

    // Frame-sync source selector.
    gcs_chan_mux #(
        .N_CH(N_CH),
        .SEL_W(SEL_W)
    ) u_fsync_mux (
        .clk(REF_CLK),
        .rst(RST),
        .ce(CE),
        .sel(fsync_sel),
        .chan_in(CH_FRAME_SYNC),
        .out_r(FRAME_SYNC_OUTPUT)
    );

    // First recovered-clock source selector.
    gcs_chan_mux #(
        .N_CH(N_CH),
        .SEL_W(SEL_W)
    ) u_recov_mux (
        .clk(REF_CLK),
        .rst(RST),
        .ce(CE),
        .sel(recov_sel),
        .chan_in(CH_RECOV_CLK),
        .out_r(RECOVERED_CLOCK_OUT_ONE)
    );

    // Strap capture with masking in fixed serial-control operation.
    gcs_strap_hold #(
        .STRAP_W(STRAP_W)
    ) u_strap (
        .clk(REF_CLK),
        .rst(RST),
        .ce(CE),
        .strap_in(STRAP_DATA),
        .mask(strap_mask),
        .strap_out_r(STRAP_CFG)
    );

    // Outputs straight from flops.
    assign RD_DATA = rd_data_r;
    assign FREQ_ADJUST = adj_r;
    assign PHASE_DECODER = phase_r;
    assign VARIABLE_MASTER_CLOCK_EN = vfreq_r;
    assign CLOCK_SYS_RESET = clk_sys_rst_r;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    // A write to the mode register followed by a read of it.
    sequence s_wr_mode;
        CE && WR_STB && ADDR == `GCS_OFF_MODE;
    endsequence

    sequence s_rd_mode;
        CE && RD_STB && ADDR == `GCS_OFF_MODE;
    endsequence

    // A standard change seen while fixed mode is active.
    sequence s_fixed_std_change;
        CE && fixed_mode && std_now != std_prev_r;
    endsequence

    AST_RESET_VALUES: assert property (
        $fell(RST) |-> clock_mode_ctrl_e1_high_r == `GCS_RST_MODE
            && global_clock_source_select_r == `GCS_RST_SRC_SEL
            && VARIABLE_MASTER_CLOCK_EN)
        else $error("Registers did not load reset values.");

    AST_MODE_READBACK: assert property (
        s_wr_mode ##1 s_rd_mode |=> RD_DATA == $past(WR_DATA, 2))
        else $error("Mode register did not read back the written value.");

    AST_FIXED_IGNORE: assert property (
        CE && fixed_mode |=> FREQ_ADJUST == '0 && PHASE_DECODER == '0)
        else $error("Adjust or decoder values leaked in fixed mode.");

    AST_STD_RESET: assert property (
        s_fixed_std_change |=> CLOCK_SYS_RESET ##1 (!CE || !CLOCK_SYS_RESET
            || $past(std_now) != $past(std_prev_r)))
        else $error("Fixed-mode standard change did not reset clocks once.");

    AST_VAR_NORESET: assert property (
        CE && !fixed_mode |=> !CLOCK_SYS_RESET)
        else $error("Clock system reset fired in variable mode.");

    AST_E1_FORM: assert property (
        CE && !fixed_mode |=> FREQ_ADJUST.e1 == $past({
            clock_mode_ctrl_e1_high_r[3:0], e1_freq_adjust_low_r}))
        else $error("E1 adjust word formed wrongly.");

    AST_T1_LOW: assert property (
        CE && !fixed_mode |=> FREQ_ADJUST.t1[7:0] == $past(t1_freq_adjust_low_r))
        else $error("T1 adjust low byte formed wrongly.");

    AST_T1_HIGH: assert property (
        CE && !fixed_mode |=>
            FREQ_ADJUST.t1[11:8] == $past(t1_freq_adjust_high_reg_r[3:0]))
        else $error("T1 adjust high nibble formed wrongly.");

    AST_PHASE_BITS: assert property (
        CE && !fixed_mode |=>
            PHASE_DECODER == $past(clock_mode_ctrl_e1_high_r[7:5]))
        else $error("Phase decoder bits not taken from the mode register.");

    AST_VFREQ_FOLLOW: assert property (
        CE |=> VARIABLE_MASTER_CLOCK_EN == !$past(fixed_mode))
        else $error("Variable clock enable does not follow bit 4.");

    AST_RD_ONE_CYCLE: assert property (
        CE && !RD_STB |=> RD_DATA == 8'h00)
        else $error("Read data stood beyond its cycle.");

endmodule : gcs_top
`default_nettype wire

// >>> rtl/gcs_cfg.svh
// Offsets, field positions and reset values of the clock source config block.
// Function
// - The frame-sync output follows the channel named by bits 6:4 of the source select register, code n meaning channel n+1.
// - The first recovered-clock output follows the channel named by bits 2:0 of the source select register, code n meaning channel n+1.
// - With the variable-frequency bit at 0 the clocking sets itself up and the E1 adjust word, the phase-decoder bits and the other clock-mode registers are ignored.
// - In fixed mode with a serial controller interface in use, the strap values sampled on data lines 15 down to 5 are disregarded.
// - In fixed mode a change of standard between E1 and T1 resets the whole clock system.
// - In variable mode each port may switch standard on its own and no clock system reset follows.
// - Bit 4 of the mode register selects variable master-clock operation when 1, and the register resets to 0x10.
// - The E1 adjust value is a signed 12-bit number, low byte from its own register and high nibble from mode register bits 3:0.
// - The T1 adjust value is a signed 12-bit number whose low byte sits in bits 7:0 of its own register.
// - Phase-decoder demand, direction and switch sit at mode bits 7, 6 and 5 and mean default operation at 0.
// - The high nibble of the T1 adjust value comes from bits 3:0 of a separate clock-mode register.
`ifndef GCS_CFG_SVH
`define GCS_CFG_SVH

// Register offsets on the control port.
`define GCS_OFF_E1_LOW 16'h0092
`define GCS_OFF_MODE 16'h0093
`define GCS_OFF_T1_LOW 16'h0094
`define GCS_OFF_T1_HIGH 16'h0095
`define GCS_OFF_STATUS 16'h0096
`define GCS_OFF_SRC_SEL 16'h00BA

// Reset values.
`define GCS_RST_E1_LOW 8'h00
`define GCS_RST_MODE 8'h10
`define GCS_RST_T1_LOW 8'h00
`define GCS_RST_T1_HIGH 8'h00
`define GCS_RST_SRC_SEL 8'h00

// Writable bits; reserved bits are held at zero.
`define GCS_MASK_SRC_SEL 8'h77
`define GCS_MASK_T1_HIGH 8'hEF

// Field positions.
`define GCS_FSYNC_SEL_HI 6
`define GCS_FSYNC_SEL_LO 4
`define GCS_RECOV_SEL_HI 2
`define GCS_RECOV_SEL_LO 0
`define GCS_DEMAND_BIT 7
`define GCS_DIRECTION_BIT 6
`define GCS_SWITCH_BIT 5
`define GCS_VFREQ_BIT 4
`define GCS_NIB_HI 3
`define GCS_NIB_LO 0

`endif

// >>> rtl/gcs_pkg.sv
// Types shared by the clock source config block.
`default_nettype none
package gcs_pkg;

    // Line standard of one port.
    typedef enum logic {
        GCS_STD_E1 = 1'b0,
        GCS_STD_T1 = 1'b1
    } gcs_std_t;

    // Strap capture progress.
    typedef enum logic {
        GCS_STRAP_WAIT = 1'b0,
        GCS_STRAP_HELD = 1'b1
    } gcs_strap_st_t;

    // Receive phase-decoder controls.
    typedef struct packed {
        logic demand;
        logic direction;
        logic sw;
    } gcs_phase_t;

    // Signed frequency adjust words.
    typedef struct packed {
        logic signed [11:0] e1;
        logic signed [11:0] t1;
    } gcs_adj_t;

endpackage : gcs_pkg
`default_nettype wire

// >>> rtl/gcs_chan_mux.sv
// Registered one-of-N channel selector.
`timescale 1ns/100ps
`default_nettype none
module gcs_chan_mux #(
    parameter int N_CH = 8,
    parameter int SEL_W = 3
) (
    // Clock and control
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Selection and channels
    input wire logic [SEL_W-1:0] sel,
    input wire logic [N_CH-1:0] chan_in,
    // Selected channel
    output logic out_r
);
    logic [N_CH-1:0] hit;
    logic out_nxt;

    // One hit term per channel; code n picks channel n+1.
    for (genvar i = 0; i < N_CH; i++) begin : g_hit
        assign hit[i] = (sel == SEL_W'(i)) & chan_in[i];
    end

    // The output is the OR of all hits.
    always_comb begin
        out_nxt = |hit;
    end

    // Registered so the pin never sees the mux glitch.
    always_ff @(posedge clk) begin
        if (rst) begin
            out_r <= 1'b0;
        end else if (ce) begin
            out_r <= out_nxt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_CHAN_ROUTE: assert property (
        ce |=> out_r == $past(chan_in[sel]))
        else $error("Selected channel not routed to output.");

endmodule : gcs_chan_mux
`default_nettype wire

// >>> rtl/gcs_strap_hold.sv
// Captures the data-line straps after reset and masks them on demand.
`timescale 1ns/100ps
`default_nettype none
module gcs_strap_hold #(
    parameter int STRAP_W = 11
) (
    // Clock and control
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Strap pins and mask
    input wire logic [STRAP_W-1:0] strap_in,
    input wire logic mask,
    // Strap values for the core
    output logic [STRAP_W-1:0] strap_out_r
);
    import gcs_pkg::*;

    gcs_strap_st_t st_r;
    gcs_strap_st_t st_nxt;
    logic [STRAP_W-1:0] held_r;
    logic [STRAP_W-1:0] held_nxt;
    logic [STRAP_W-1:0] out_nxt;

    // Straps are caught on the first enabled cycle after reset, never under
    // reset itself, so the flops take only constants while it is asserted.
    always_comb begin
        st_nxt = st_r;
        held_nxt = held_r;
        case (st_r)
            GCS_STRAP_WAIT: begin
                held_nxt = strap_in;
                st_nxt = GCS_STRAP_HELD;
            end
            GCS_STRAP_HELD: begin
                st_nxt = GCS_STRAP_HELD;
            end
            default: begin
                st_nxt = GCS_STRAP_WAIT;
            end
        endcase
        out_nxt = mask ? '0 : held_nxt;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= GCS_STRAP_WAIT;
            held_r <= '0;
            strap_out_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
            held_r <= held_nxt;
            strap_out_r <= out_nxt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_STRAP_MASK: assert property (
        ce && mask |=> strap_out_r == '0)
        else $error("Straps not disregarded while masked.");

    AST_STRAP_KEPT: assert property (
        ce && !mask && st_r == GCS_STRAP_HELD |=> strap_out_r == $past(held_r))
        else $error("Captured straps not presented while unmasked.");

endmodule : gcs_strap_hold
`default_nettype wire

// >>> tb/global_clock_source_config_tb_top.sv
// Self-checking testbench of the clock source config block.
`timescale 1ns/100ps
`default_nettype none
`include "gcs_cfg.svh"
module global_clock_source_config_tb_top;
    import gcs_pkg::*;

    // Stimulus and observed signals.
    logic REF_CLK, RST, CE, WR_STB, RD_STB, SERIAL_CTRL_IF;
    logic [15:0] ADDR;
    logic [7:0] WR_DATA, RD_DATA, CH_FRAME_SYNC, CH_RECOV_CLK, CH_STD_T1;
    logic [10:0] STRAP_DATA, STRAP_CFG;
    logic FRAME_SYNC_OUTPUT, RECOVERED_CLOCK_OUT_ONE;
    logic VARIABLE_MASTER_CLOCK_EN, CLOCK_SYS_RESET;
    gcs_adj_t FREQ_ADJUST;
    gcs_phase_t PHASE_DECODER;
    int fails = 0;
    int num_checks = 0;
    int pulses = 0;
    int cycles = 0;
    int p0;
    int seed = 32'h0000_0b64;
    logic [7:0] v, fs, rc, e1l, t1l, md, t1h;

    gcs_top gcs_top_i (
        .REF_CLK(REF_CLK), .RST(RST), .CE(CE), .ADDR(ADDR),
        .WR_DATA(WR_DATA), .WR_STB(WR_STB), .RD_STB(RD_STB),
        .RD_DATA(RD_DATA), .CH_FRAME_SYNC(CH_FRAME_SYNC),
        .CH_RECOV_CLK(CH_RECOV_CLK), .CH_STD_T1(CH_STD_T1),
        .SERIAL_CTRL_IF(SERIAL_CTRL_IF), .STRAP_DATA(STRAP_DATA),
        .FRAME_SYNC_OUTPUT(FRAME_SYNC_OUTPUT),
        .RECOVERED_CLOCK_OUT_ONE(RECOVERED_CLOCK_OUT_ONE),
        .FREQ_ADJUST(FREQ_ADJUST), .PHASE_DECODER(PHASE_DECODER),
        .VARIABLE_MASTER_CLOCK_EN(VARIABLE_MASTER_CLOCK_EN),
        .CLOCK_SYS_RESET(CLOCK_SYS_RESET), .STRAP_CFG(STRAP_CFG)
    );

    // A 40 MHz clock.
    initial begin
        REF_CLK = 1'b0;
        forever #12.5 REF_CLK = ~REF_CLK;
    end

    // Pulse counter and hang guard; the run needs far fewer cycles.
    always @(posedge REF_CLK) begin
        cycles <= cycles + 1;
        if (CLOCK_SYS_RESET === 1'b1) pulses <= pulses + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            give_verdict();
        end
    end

    // Compare tasks, one per kind of result.
    task automatic cmp_reg(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp_reg

    task automatic cmp_bit(input string nm, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %b seen %b", nm, e, g);
        end
    endtask : cmp_bit

    task automatic cmp_word(input string nm, input logic [23:0] e,
        input logic [23:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp_word

    // Expected adjust outputs; fixed mode hides both words.
    function automatic logic [23:0] exp_adj(input logic vm,
        input logic [7:0] m, el, th, tl);
        return vm ? {m[3:0], el, th[3:0], tl} : 24'h00_0000;
    endfunction : exp_adj

    // Straps vanish only in fixed mode with a serial controller.
    function automatic logic [23:0] exp_strap(input logic vm, sif,
        input logic [10:0] s);
        return (!vm && sif) ? 24'h00_0000 : {13'h0000, s};
    endfunction : exp_strap

    // Register port master; strobes last one cycle.
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge REF_CLK);
        WR_STB <= 1'b1;
        ADDR <= a;
        WR_DATA <= d;
        @(posedge REF_CLK);
        WR_STB <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe.
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e,
        input string nm);
        @(posedge REF_CLK);
        RD_STB <= 1'b1;
        ADDR <= a;
        @(posedge REF_CLK);
        RD_STB <= 1'b0;
        #1;
        cmp_reg(nm, e, RD_DATA);
    endtask : rd_chk

    task automatic tick(input int n);
        repeat (n) @(posedge REF_CLK);
        #1;
    endtask : tick

    // Ends the run with the verdict.
    task automatic give_verdict();
        if (fails == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    // Main sequence.
    initial begin
        RST = 1'b1;
        CE = 1'b1;
        WR_STB = 1'b0;
        RD_STB = 1'b0;
        ADDR = 16'h0000;
        WR_DATA = 8'h00;
        CH_FRAME_SYNC = 8'h00;
        CH_RECOV_CLK = 8'h00;
        CH_STD_T1 = 8'h00;
        SERIAL_CTRL_IF = 1'b1;
        STRAP_DATA = 11'($random(seed));
        repeat (6) @(posedge REF_CLK);
        RST <= 1'b0;
        rd_chk(`GCS_OFF_MODE, `GCS_RST_MODE, "mode");
        rd_chk(`GCS_OFF_SRC_SEL, `GCS_RST_SRC_SEL, "src");
        rd_chk(`GCS_OFF_E1_LOW, `GCS_RST_E1_LOW, "e1_lo");
        rd_chk(`GCS_OFF_T1_LOW, `GCS_RST_T1_LOW, "t1_lo");
        rd_chk(`GCS_OFF_T1_HIGH, `GCS_RST_T1_HIGH, "t1_hi");
        cmp_bit("vm_en", 1'b1, VARIABLE_MASTER_CLOCK_EN);
        cmp_word("strap", exp_strap(1, 1, STRAP_DATA), STRAP_CFG);
        wr(16'h0097, 8'hFF);
        rd_chk(16'h0097, 8'h00, "unmapped");
        // Every selector code, with random channel activity behind it.
        for (int c = 0; c < 8; c++) begin
            v = $random(seed);
            v[6:4] = c[2:0];
            v[2:0] = 3'd7 - c[2:0];
            wr(`GCS_OFF_SRC_SEL, v);
            rd_chk(`GCS_OFF_SRC_SEL, v & `GCS_MASK_SRC_SEL, "src");
            repeat (3) begin
                @(posedge REF_CLK);
                fs = $random(seed);
                rc = $random(seed);
                CH_FRAME_SYNC <= fs;
                CH_RECOV_CLK <= rc;
                tick(1);
                cmp_bit("fsync", fs[c], FRAME_SYNC_OUTPUT);
                cmp_bit("recovered_clock_out_one", rc[7-c], RECOVERED_CLOCK_OUT_ONE);
            end
        end
        // A strobe with the enable low must leave the register alone.
        @(posedge REF_CLK);
        CE <= 1'b0;
        wr(`GCS_OFF_SRC_SEL, ~v);
        CE <= 1'b1;
        rd_chk(`GCS_OFF_SRC_SEL, v & `GCS_MASK_SRC_SEL, "src_ce");
        // Adjust words in variable mode, extremes first; phase bits kept 0.
        for (int k = 0; k < 6; k++) begin
            e1l = $random(seed);
            t1l = $random(seed);
            t1h = $random(seed);
            md = {4'h1, 4'($random(seed))};
            if (k == 0) begin
                e1l = 8'h00;
                md = 8'h18;
                t1l = 8'hFF;
                t1h = 8'h07;
            end else if (k == 1) begin
                e1l = 8'hFF;
                md = 8'h17;
                t1l = 8'h00;
                t1h = 8'hF8;
            end
            wr(`GCS_OFF_E1_LOW, e1l);
            wr(`GCS_OFF_MODE, md);
            wr(`GCS_OFF_T1_LOW, t1l);
            wr(`GCS_OFF_T1_HIGH, t1h);
            tick(3);
            cmp_word("adjust", exp_adj(1, md, e1l, t1h, t1l), FREQ_ADJUST);
            cmp_word("phase", 24'h00_0000, 24'(PHASE_DECODER));
            rd_chk(`GCS_OFF_T1_HIGH, t1h & `GCS_MASK_T1_HIGH, "t1_hi");
            rd_chk(`GCS_OFF_E1_LOW, e1l, "e1_lo");
        end
        // Fixed mode hides adjust and phase controls, and the straps only with a serial controller.
        md = {3'($random(seed)) | 3'h1, 1'b0, 4'($random(seed))};
        wr(`GCS_OFF_MODE, md);
        tick(3);
        cmp_bit("vm_en", 1'b0, VARIABLE_MASTER_CLOCK_EN);
        cmp_word("adjust", exp_adj(0, md, e1l, t1h, t1l), FREQ_ADJUST);
        cmp_word("phase", 24'h00_0000, 24'(PHASE_DECODER));
        cmp_word("strap", exp_strap(0, 1, STRAP_DATA), STRAP_CFG);
        rd_chk(`GCS_OFF_MODE, md, "mode");
        rd_chk(`GCS_OFF_STATUS, 8'h09, "status");
        @(posedge REF_CLK);
        SERIAL_CTRL_IF <= 1'b0;
        tick(2);
        cmp_word("strap", exp_strap(0, 0, STRAP_DATA), STRAP_CFG);
        // Fixed mode: all ports switch standard together, once each way.
        p0 = pulses;
        @(posedge REF_CLK);
        CH_STD_T1 <= 8'hFF;
        tick(5);
        cmp_word("sys_rst", 24'(p0 + 1), 24'(pulses));
        rd_chk(`GCS_OFF_STATUS, 8'h05, "status");
        @(posedge REF_CLK);
        CH_STD_T1 <= 8'h00;
        tick(5);
        cmp_word("sys_rst", 24'(p0 + 2), 24'(pulses));
        // Variable mode: ports switch on their own without a reset.
        wr(`GCS_OFF_MODE, 8'h10);
        repeat (4) begin
            @(posedge REF_CLK);
            CH_STD_T1 <= {7'($random(seed)), ~CH_STD_T1[0]};
            tick(3);
        end
        @(posedge REF_CLK);
        CH_STD_T1 <= 8'h01;
        rd_chk(`GCS_OFF_STATUS, 8'h06, "status");
        cmp_word("sys_rst", 24'(p0 + 2), 24'(pulses));
        // A write read back with no gap, then a mid-run reset must undo it.
        @(posedge REF_CLK);
        WR_STB <= 1'b1;
        ADDR <= `GCS_OFF_MODE;
        WR_DATA <= 8'h1F;
        @(posedge REF_CLK);
        WR_STB <= 1'b0;
        RD_STB <= 1'b1;
        @(posedge REF_CLK);
        RD_STB <= 1'b0;
        #1;
        cmp_reg("mode_b2b", 8'h1F, RD_DATA);
        @(posedge REF_CLK);
        RST <= 1'b1;
        repeat (2) @(posedge REF_CLK);
        RST <= 1'b0;
        rd_chk(`GCS_OFF_MODE, `GCS_RST_MODE, "mode");
        rd_chk(`GCS_OFF_SRC_SEL, `GCS_RST_SRC_SEL, "src");
        give_verdict();
    end
endmodule : global_clock_source_config_tb_top
`default_nettype wire
